// ==== hw/csab_consts.vh ====
// constants for the chip select area bus block
`ifndef CSAB_CONSTS_VH
`define CSAB_CONSTS_VH
// register indices, byte address is four times the index
`define CSAB_IDX_AREA_START   11'h640
`define CSAB_IDX_AREA_CONFIG  11'h642
`define CSAB_IDX_AREA_WAIT    11'h660
`define CSAB_IDX_MODE_VECTOR  11'h7fd
`define CSAB_IDX_STANDBY      11'h680
`define CSAB_IDX_STATUS       11'h681
// reset values
`define CSAB_RST_AREA_START   16'h0000
`define CSAB_RST_AREA_CONFIG  16'h0022
`define CSAB_RST_AREA_WAIT    16'h0000
`define CSAB_RST_MODE_VECTOR  8'h00
`define CSAB_RST_STANDBY      8'h00
// mode vector
`define CSAB_MODE_INTMEM_BIT  2
`define CSAB_MODE_WIDTH_MSB   1
`define CSAB_MODE_WIDTH_LSB   0
// area config fields
`define CSAB_CFG_SIZE_MSB     15
`define CSAB_CFG_SIZE_LSB     12
`define CSAB_CFG_WIDTH_MSB    11
`define CSAB_CFG_WIDTH_LSB    10
`define CSAB_CFG_BURST_MSB    9
`define CSAB_CFG_BURST_LSB    8
`define CSAB_CFG_SHARE_BIT    7
`define CSAB_CFG_PREFETCH_BIT 6
`define CSAB_CFG_WRPERMIT_BIT 5
`define CSAB_CFG_LITTLE_ENDIAN_SELECT_BIT     4
`define CSAB_CFG_TYPE_MSB     3
`define CSAB_CFG_TYPE_LSB     0
`define CSAB_TYPE_WEX         4'h2
`define CSAB_WIDTH_16         2'h1
`define CSAB_BURST_SINGLE     2'h0
// area wait fields
`define CSAB_WAIT_AUTO_MSB    15
`define CSAB_WAIT_AUTO_LSB    12
`define CSAB_WAIT_REC_MSB     7
`define CSAB_WAIT_REC_LSB     6
`define CSAB_WAIT_WW_MSB      5
`define CSAB_WAIT_WW_LSB      4
`define CSAB_WAIT_HALF_BIT    3
`define CSAB_WAIT_CS_BIT      2
`define CSAB_WAIT_SETUP_BIT   1
`define CSAB_WAIT_HOLD_BIT    0
// standby control bits
`define CSAB_SBY_STOP_BIT     0
`define CSAB_SBY_FLOAT_BIT    1
`define CSAB_SBY_PULLUP_BIT   2
// request sizes
`define CSAB_SIZE_BYTE        2'h0
`define CSAB_SIZE_HALF        2'h1
`define CSAB_SIZE_WORD        2'h2
// core clocks per memory clock cycle
`define CSAB_CLK_PER_MCYC     6'h02
`endif

// ==== hw/csab_area_match.v ====
// area base and size compare for one chip select area
`timescale 1ns/1ps
`default_nettype none
module csab_area_match (
	input  wire [15:0] base,
	input  wire [3:0]  size_code,
	input  wire [31:0] addr,
	output wire        hit
);
	wire [15:0] offs;
	wire [16:0] span;

	// span in 64 kbyte units: 0101 gives 32 units, two megabytes
	assign span = 17'h00001 << size_code;
	assign offs = addr[31:16] - base;
	assign hit  = ({1'b0, offs} < span);
endmodule // csab_area_match
`default_nettype wire

// ==== hw/csab_phase_timer.v ====
// down counter that times one bus phase
`timescale 1ns/1ps
`default_nettype none
module csab_phase_timer (
	input  wire       clk,
	input  wire       srst,
	input  wire       load,
	input  wire [5:0] len,
	input  wire       hold,
	output wire       last
);
	reg [5:0] cnt_r;

	always @(posedge clk) begin
		if (srst)
			cnt_r <= 6'h00;
		else if (load)
			cnt_r <= (len == 6'h00) ? 6'h00 : len - 6'h01;
		else if (cnt_r != 6'h00 && !hold)
			cnt_r <= cnt_r - 6'h01;
	end

	assign last = (cnt_r == 6'h00) && !hold;
endmodule // csab_phase_timer
`default_nettype wire

// ==== hw/csab_top.v ====
// chip select area zero bus controller with avalon register slave
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "csab_consts.vh"
module csab_top (
	input  wire        CORE_CLK,
	input  wire        SRST,
	input  wire [10:0] AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [31:0] AVS_WRITEDATA,
	input  wire [3:0]  AVS_BYTEENABLE,
	output reg  [31:0] AVS_READDATA,
	output wire        AVS_WAITREQUEST,
	input  wire        REQ_VALID,
	output wire        REQ_READY,
	input  wire        REQ_WRITE,
	input  wire [1:0]  REQ_SIZE,
	input  wire [31:0] REQ_ADDR,
	input  wire [31:0] REQ_WDATA,
	output reg         RSP_VALID,
	output reg  [31:0] RSP_RDATA,
	output reg         RSP_ERR,
	output reg         MEM_CLK,
	output reg  [23:0] MEM_ADDR,
	output reg         MEM_CS0_N,
	output reg         MEM_RD_N,
	output reg         MEM_WR0_N,
	output reg         MEM_WR1_N,
	output reg  [15:0] MEM_DATA_OUT,
	output reg         MEM_DATA_OE_N,
	input  wire [15:0] MEM_DATA_IN,
	input  wire        MEM_RDY,
	output wire        MEM_CTRL_OE_N,
	output wire        MEM_PULLUP_EN,
	input  wire        EXT_BUS_REQUEST,
	output reg         EXT_BUS_GRANT,
	output wire        INT_MEM_EN
);
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam S_IDLE  = 6'b000001;
	localparam S_SETUP = 6'b000010;
	localparam S_STRB  = 6'b000100;
	localparam S_HOLD  = 6'b001000;
	localparam S_RECOV = 6'b010000;
	localparam S_DONE  = 6'b100000;

	reg [15:0] area_start_r;
	reg [15:0] area_config_r;
	reg [15:0] area_wait_r;
	reg [7:0]  mode_vector_r;
	reg [7:0]  standby_r;
	reg        wr_refused_r;
	reg        ack_r;
	reg [5:0]  state_r;
	reg [5:0]  state_nxt;
	reg        beat_r;
	reg        two_beat_r;
	reg        wr_r;
	reg [1:0]  size_r;
	reg [31:0] addr_r;
	reg [31:0] wdata_r;
	reg [31:0] rdata_r;
	reg        err_r;
	reg        pf_valid_r;
	reg [29:0] pf_addr_r;
	reg [31:0] pf_data_r;
	reg        strb_seen_r;
	reg [5:0]  len_nxt;

	// ------------------------------------------------------------
	// field views
	// ------------------------------------------------------------
	wire [3:0] size_field  = area_config_r[`CSAB_CFG_SIZE_MSB:`CSAB_CFG_SIZE_LSB];
	wire [1:0] width_field = area_config_r[`CSAB_CFG_WIDTH_MSB:`CSAB_CFG_WIDTH_LSB];
	wire [1:0] burst_field = area_config_r[`CSAB_CFG_BURST_MSB:`CSAB_CFG_BURST_LSB];
	wire       share_en    = area_config_r[`CSAB_CFG_SHARE_BIT];
	wire       prefetch_en = area_config_r[`CSAB_CFG_PREFETCH_BIT];
	wire       write_permit = area_config_r[`CSAB_CFG_WRPERMIT_BIT];
	wire       little_endian_select        = area_config_r[`CSAB_CFG_LITTLE_ENDIAN_SELECT_BIT];
	wire [3:0] type_field  = area_config_r[`CSAB_CFG_TYPE_MSB:`CSAB_CFG_TYPE_LSB];
	wire       write_strobe_style         = (type_field == `CSAB_TYPE_WEX);
	wire [3:0] auto_wait   = area_wait_r[`CSAB_WAIT_AUTO_MSB:`CSAB_WAIT_AUTO_LSB];
	wire [1:0] rec_dly     = area_wait_r[`CSAB_WAIT_REC_MSB:`CSAB_WAIT_REC_LSB];
	wire [1:0] ww_dly      = area_wait_r[`CSAB_WAIT_WW_MSB:`CSAB_WAIT_WW_LSB];
	wire       half_dly    = area_wait_r[`CSAB_WAIT_HALF_BIT];
	wire       cs_dly      = area_wait_r[`CSAB_WAIT_CS_BIT];
	wire       setup_dly   = area_wait_r[`CSAB_WAIT_SETUP_BIT];
	wire       hold_dly    = area_wait_r[`CSAB_WAIT_HOLD_BIT];
	wire       stop_mode   = standby_r[`CSAB_SBY_STOP_BIT];
	wire       stop_float  = standby_r[`CSAB_SBY_FLOAT_BIT];
	wire       floated     = (stop_mode & stop_float) | EXT_BUS_GRANT;
	wire       area_hit;
	wire       ph_last;
	wire       rdy_hold;

	// memory cycles to core clocks
	function [5:0] mcyc;
		input [4:0] n;
		begin
			mcyc = {n, 1'b0};
		end
	endfunction

	// ------------------------------------------------------------
	// avalon register slave, one wait state per access
	// ------------------------------------------------------------
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
	wire   reg_wr = AVS_WRITE & ack_r;
	wire   sts_clr = reg_wr && AVS_ADDRESS == `CSAB_IDX_STATUS &&
		AVS_BYTEENABLE[0] && AVS_WRITEDATA[1];
	wire   refuse_set = (state_r == S_IDLE) && REQ_VALID && REQ_READY &&
		REQ_WRITE && area_hit && !write_permit;

	always @(posedge CORE_CLK) begin
		if (SRST) begin
			ack_r         <= 1'b0;
			AVS_READDATA  <= 32'h00000000;
			area_start_r  <= `CSAB_RST_AREA_START;
			area_config_r <= `CSAB_RST_AREA_CONFIG;
			area_wait_r   <= `CSAB_RST_AREA_WAIT;
			mode_vector_r <= `CSAB_RST_MODE_VECTOR;
			standby_r     <= `CSAB_RST_STANDBY;
			wr_refused_r  <= 1'b0;
		end else begin
			ack_r <= (AVS_READ | AVS_WRITE) & ~ack_r;
			if (AVS_READ && !ack_r) begin
				case (AVS_ADDRESS)
				`CSAB_IDX_AREA_START:  AVS_READDATA <= {16'h0000, area_start_r};
				`CSAB_IDX_AREA_CONFIG: AVS_READDATA <= {16'h0000, area_config_r};
				`CSAB_IDX_AREA_WAIT:   AVS_READDATA <= {16'h0000, area_wait_r};
				`CSAB_IDX_MODE_VECTOR: AVS_READDATA <= {24'h000000, mode_vector_r};
				`CSAB_IDX_STANDBY:     AVS_READDATA <= {24'h000000, standby_r};
				`CSAB_IDX_STATUS:      AVS_READDATA <= {28'h0000000,
					EXT_BUS_GRANT, pf_valid_r, wr_refused_r,
					~state_r[0]};
				default:               AVS_READDATA <= 32'h00000000;
				endcase
			end
			if (reg_wr) begin
				case (AVS_ADDRESS)
				`CSAB_IDX_AREA_START: begin
					if (AVS_BYTEENABLE[0])
						area_start_r[7:0] <= AVS_WRITEDATA[7:0];
					if (AVS_BYTEENABLE[1])
						area_start_r[15:8] <= AVS_WRITEDATA[15:8];
				end
				`CSAB_IDX_AREA_CONFIG: begin
					if (AVS_BYTEENABLE[0])
						area_config_r[7:0] <= AVS_WRITEDATA[7:0];
					if (AVS_BYTEENABLE[1])
						area_config_r[15:8] <= AVS_WRITEDATA[15:8];
				end
				`CSAB_IDX_AREA_WAIT: begin
					if (AVS_BYTEENABLE[0])
						area_wait_r[7:0] <= AVS_WRITEDATA[7:0];
					if (AVS_BYTEENABLE[1])
						area_wait_r[15:8] <= AVS_WRITEDATA[15:8];
				end
				`CSAB_IDX_MODE_VECTOR: begin
					if (AVS_BYTEENABLE[0]) begin
						mode_vector_r <= AVS_WRITEDATA[7:0];
						// area zero width follows the mode vector
						area_config_r[`CSAB_CFG_WIDTH_MSB:`CSAB_CFG_WIDTH_LSB] <=
							AVS_WRITEDATA[`CSAB_MODE_WIDTH_MSB:`CSAB_MODE_WIDTH_LSB];
					end
				end
				`CSAB_IDX_STANDBY: begin
					if (AVS_BYTEENABLE[0])
						standby_r <= AVS_WRITEDATA[7:0];
				end
				default: begin
				end
				endcase
			end
			// set wins over clear
			if (refuse_set)
				wr_refused_r <= 1'b1;
			else if (sts_clr)
				wr_refused_r <= 1'b0;
		end
	end

	assign INT_MEM_EN = mode_vector_r[`CSAB_MODE_INTMEM_BIT];
	assign MEM_PULLUP_EN = standby_r[`CSAB_SBY_PULLUP_BIT] &
		~(stop_mode & stop_float);
	assign MEM_CTRL_OE_N = floated;

	// ------------------------------------------------------------
	// area decode and request acceptance
	// ------------------------------------------------------------
	csab_area_match u_match (
		.base      (area_start_r),
		.size_code (size_field),
		.addr      (REQ_ADDR),
		.hit       (area_hit)
	);

	assign REQ_READY = (state_r == S_IDLE) & ~floated & ~RSP_VALID;
	wire pf_hit = prefetch_en && pf_valid_r && !REQ_WRITE &&
		REQ_SIZE == `CSAB_SIZE_WORD && pf_addr_r == REQ_ADDR[31:2];
	// ready input honoured only outside write strobe style
	assign rdy_hold = (state_r == S_STRB) && !write_strobe_style && !MEM_RDY;

	// ------------------------------------------------------------
	// bus phase sequencer
	// ------------------------------------------------------------
	always @* begin
		state_nxt = state_r;
		len_nxt = 6'h00;
		case (state_r)
		S_IDLE: begin
			if (REQ_VALID && REQ_READY && area_hit && !pf_hit &&
				!(REQ_WRITE && !write_permit)) begin
				state_nxt = S_SETUP;
				len_nxt = mcyc({4'h0, cs_dly}) +
					mcyc({4'h0, setup_dly}) + {5'h00, half_dly};
			end else if (REQ_VALID && REQ_READY)
				state_nxt = S_DONE;
		end
		S_SETUP: begin
			if (ph_last) begin
				state_nxt = S_STRB;
				// strobe ends on the memory clock, start was delayed
				len_nxt = mcyc({1'b0, auto_wait} + 5'h01) -
					{5'h00, half_dly};
			end
		end
		S_STRB: begin
			if (ph_last) begin
				state_nxt = S_HOLD;
				len_nxt = mcyc({4'h0, hold_dly});
			end
		end
		S_HOLD: begin
			if (ph_last) begin
				state_nxt = S_RECOV;
				if (wr_r && write_strobe_style && ww_dly > rec_dly)
					len_nxt = mcyc({3'h0, ww_dly});
				else
					len_nxt = mcyc({3'h0, rec_dly});
			end
		end
		S_RECOV: begin
			if (ph_last) begin
				if (two_beat_r && !beat_r) begin
					state_nxt = S_SETUP;
					len_nxt = mcyc({4'h0, cs_dly}) +
						mcyc({4'h0, setup_dly}) + {5'h00, half_dly};
				end else
					state_nxt = S_DONE;
			end
		end
		S_DONE:
			state_nxt = S_IDLE;
		default:
			state_nxt = S_IDLE;
		endcase
	end

	csab_phase_timer u_timer (
		.clk  (CORE_CLK),
		.srst (SRST),
		.load (state_nxt != state_r || (state_r == S_RECOV &&
			state_nxt == S_SETUP)),
		.len  (len_nxt),
		.hold (rdy_hold),
		.last (ph_last)
	);

	// ------------------------------------------------------------
	// request capture, data steering and response
	// ------------------------------------------------------------
	wire [31:0] beat_addr = two_beat_r ?
		{addr_r[31:2], beat_r, 1'b0} : addr_r;
	// big endian puts the upper half first
	wire        upper_half = two_beat_r ? (beat_r == little_endian_select) : 1'b0;
	wire        lane_hi = (size_r != `CSAB_SIZE_BYTE) ||
		(addr_r[0] == little_endian_select);
	wire        lane_lo = (size_r != `CSAB_SIZE_BYTE) ||
		(addr_r[0] != little_endian_select);

	always @(posedge CORE_CLK) begin
		if (SRST) begin
			state_r <= S_IDLE;
			beat_r <= 1'b0;
			two_beat_r <= 1'b0;
			wr_r <= 1'b0;
			size_r <= `CSAB_SIZE_BYTE;
			addr_r <= 32'h00000000;
			wdata_r <= 32'h00000000;
			rdata_r <= 32'h00000000;
			err_r <= 1'b0;
			pf_valid_r <= 1'b0;
			pf_addr_r <= 30'h00000000;
			pf_data_r <= 32'h00000000;
			RSP_VALID <= 1'b0;
			RSP_RDATA <= 32'h00000000;
			RSP_ERR <= 1'b0;
			EXT_BUS_GRANT <= 1'b0;
			strb_seen_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			RSP_VALID <= 1'b0;
			// grant only between transfers, requests dropped when off
			if (state_r == S_IDLE && !REQ_VALID)
				EXT_BUS_GRANT <= share_en & EXT_BUS_REQUEST;
			if (state_r == S_IDLE && REQ_VALID && REQ_READY) begin
				wr_r <= REQ_WRITE;
				size_r <= REQ_SIZE;
				addr_r <= REQ_ADDR;
				wdata_r <= REQ_WDATA;
				beat_r <= 1'b0;
				two_beat_r <= REQ_SIZE == `CSAB_SIZE_WORD &&
					width_field == `CSAB_WIDTH_16 &&
					burst_field == `CSAB_BURST_SINGLE;
				err_r <= !area_hit || (REQ_WRITE && !write_permit);
				rdata_r <= pf_hit ? pf_data_r : 32'h00000000;
				if (REQ_WRITE)
					pf_valid_r <= 1'b0;
			end
			if (state_r == S_STRB && ph_last) begin
				if (!wr_r && upper_half)
					rdata_r[31:16] <= MEM_DATA_IN;
				else if (!wr_r)
					rdata_r[15:0] <= MEM_DATA_IN;
			end
			if (state_r == S_RECOV && ph_last)
				beat_r <= 1'b1;
			if (state_r == S_DONE) begin
				RSP_VALID <= 1'b1;
				RSP_ERR <= err_r;
				RSP_RDATA <= rdata_r;
				if (!wr_r && !err_r && size_r == `CSAB_SIZE_WORD &&
					prefetch_en) begin
					pf_valid_r <= 1'b1;
					pf_addr_r <= addr_r[31:2];
					pf_data_r <= rdata_r;
				end
			end
			strb_seen_r <= (state_nxt == S_STRB);
		end
	end

	// ------------------------------------------------------------
	// memory pins, registered
	// ------------------------------------------------------------
	wire cs_on = (state_r == S_SETUP && !(cs_dly &&
		state_nxt == S_SETUP && strb_seen_r == 1'b0 && !setup_dly)) ||
		state_r == S_STRB || state_r == S_HOLD;
	wire strb_on = (state_nxt == S_STRB);

	always @(posedge CORE_CLK) begin
		if (SRST) begin
			MEM_CLK <= 1'b0;
			MEM_ADDR <= 24'h000000;
			MEM_CS0_N <= 1'b1;
			MEM_RD_N <= 1'b1;
			MEM_WR0_N <= 1'b1;
			MEM_WR1_N <= 1'b1;
			MEM_DATA_OUT <= 16'h0000;
			MEM_DATA_OE_N <= 1'b1;
		end else begin
			MEM_CLK <= ~MEM_CLK;
			MEM_ADDR <= beat_addr[23:0];
			MEM_CS0_N <= ~cs_on;
			// separate read and per-byte write strobes
			MEM_RD_N <= ~(strb_on && !wr_r);
			MEM_WR0_N <= ~(strb_on && wr_r && lane_hi);
			MEM_WR1_N <= ~(strb_on && wr_r && lane_lo);
			if (size_r == `CSAB_SIZE_BYTE)
				MEM_DATA_OUT <= {wdata_r[7:0], wdata_r[7:0]};
			else if (upper_half)
				MEM_DATA_OUT <= wdata_r[31:16];
			else
				MEM_DATA_OUT <= wdata_r[15:0];
			MEM_DATA_OE_N <= ~(wr_r && (state_nxt == S_SETUP ||
				state_nxt == S_STRB || state_nxt == S_HOLD));
		end
	end
endmodule // csab_top
`default_nettype wire

// ==== tb/csab_sram_model.sv ====
// halfword asynchronous memory model for the external bus
`timescale 1ns/1ps
`default_nettype none
module csab_sram_model (
	input  wire logic        clk,
	input  wire logic        stall,
	input  wire logic [23:0] addr,
	input  wire logic        cs_n,
	input  wire logic        rd_n,
	input  wire logic        wr0_n,
	input  wire logic        wr1_n,
	input  wire logic [15:0] din,
	output logic      [15:0] dout,
	output logic             rdy
);
	// ------------------------------
	// storage, byte strobes, read bus
	// ------------------------------
	logic [15:0] mem [0:255];
	logic [15:0] last_q;
	initial begin
		last_q = 16'h0000;
		for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
	end
	assign rdy = ~stall;
	always @(posedge clk) begin
		if (!cs_n && !wr0_n) mem[addr[8:1]][15:8] <= din[15:8];
		if (!cs_n && !wr1_n) mem[addr[8:1]][7:0] <= din[7:0];
		if (!cs_n && !rd_n) last_q <= mem[addr[8:1]];
	end
	// released bus shows inverted last value
	assign dout = (!cs_n && !rd_n) ? mem[addr[8:1]] : ~last_q;
endmodule // csab_sram_model
`default_nettype wire

// ==== tb/csab_props.sv ====
// assertion checker for the chip select area bus block
`timescale 1ns/1ps
`default_nettype none
module csab_props (
	input wire logic        CORE_CLK,
	input wire logic        SRST,
	input wire logic [10:0] AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        REQ_VALID,
	input wire logic        REQ_READY,
	input wire logic        REQ_WRITE,
	input wire logic [31:0] REQ_ADDR,
	input wire logic        RSP_VALID,
	input wire logic        RSP_ERR,
	input wire logic        MEM_CS0_N,
	input wire logic        MEM_RD_N,
	input wire logic        MEM_WR0_N,
	input wire logic        MEM_WR1_N,
	input wire logic        EXT_BUS_GRANT,
	input wire logic        INT_MEM_EN
);
	// ----------------
	// shadow registers
	// ----------------
	logic [15:0] cfg_r, wt_r, st_r;
	wire acc = AVS_WRITE && !AVS_WAITREQUEST;
	wire wr_n = MEM_WR0_N & MEM_WR1_N;
	wire [15:0] up = REQ_ADDR[31:16];
	wire out_a = up < st_r || up >= st_r + 16'h0020;
	wire bad = out_a || (REQ_WRITE && !cfg_r[5]);
	always @(posedge CORE_CLK) begin
		if (SRST) begin
			cfg_r <= 16'h0022;
			wt_r <= 16'h0000;
			st_r <= 16'h0000;
		end else if (acc) begin
			if (AVS_ADDRESS == 11'h640) st_r <= AVS_WRITEDATA[15:0];
			if (AVS_ADDRESS == 11'h642) cfg_r <= AVS_WRITEDATA[15:0];
			if (AVS_ADDRESS == 11'h660) wt_r <= AVS_WRITEDATA[15:0];
		end
	end
	// ----------
	// properties
	// ----------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SRST);
	chk_one_wait: assert property ($rose(AVS_READ || AVS_WRITE) |->
		AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("wait count wrong");
	chk_mode_intmem: assert property (
		acc && AVS_ADDRESS == 11'h7fd |=> INT_MEM_EN == $past(AVS_WRITEDATA[2]))
		else $error("internal memory enable wrong");
	chk_grant_off: assert property (
		!cfg_r[7] && !$past(cfg_r[7]) |-> !EXT_BUS_GRANT)
		else $error("grant without sharing");
	chk_auto_wait: assert property (
		$fell(MEM_RD_N) && wt_r[15:12] == 4'h2 && wt_r[3] &&
		cfg_r[3:0] == 4'h2 |->
		(!MEM_RD_N)[*5] ##1 MEM_RD_N) else $error("read strobe length wrong");
	chk_read_gap: assert property (
		$rose(MEM_RD_N) && wt_r[7:6] == 2'h1 |-> (MEM_RD_N && wr_n)[*2])
		else $error("read recovery short");
	chk_write_gap: assert property (
		$rose(wr_n) && wt_r[5:4] == 2'h1 && cfg_r[3:0] == 4'h2 |->
		(wr_n && MEM_RD_N)[*2]) else $error("write gap short");
	chk_one_out: assert property (REQ_VALID && REQ_READY |=> !REQ_READY)
		else $error("second request taken");
	chk_refuse_req: assert property (
		REQ_VALID && REQ_READY && cfg_r[15:12] == 4'h5 && bad |->
		(MEM_CS0_N[*3]) and (##2 (RSP_VALID && RSP_ERR)))
		else $error("refused request reached the bus");
	cov_err: cover property (RSP_VALID && RSP_ERR);
	cov_rd: cover property ($fell(MEM_RD_N));
	cov_wr: cover property ($fell(wr_n));
endmodule // csab_props
bind csab_top csab_props chk_u (.CORE_CLK, .SRST, .AVS_ADDRESS, .AVS_READ,
	.AVS_WRITE, .AVS_WRITEDATA, .AVS_WAITREQUEST, .REQ_VALID, .REQ_READY,
	.REQ_WRITE, .REQ_ADDR, .RSP_VALID, .RSP_ERR, .MEM_CS0_N, .MEM_RD_N,
	.MEM_WR0_N, .MEM_WR1_N, .EXT_BUS_GRANT, .INT_MEM_EN);
`default_nettype wire

// ==== tb/test_chip_select_area_bus_config.sv ====
// self-checking bench for the chip select area bus block
`timescale 1ns/1ps
`default_nettype none
module test_chip_select_area_bus_config;
	typedef struct {
		logic        w;
		logic [1:0]  s;
		logic [31:0] a, d, x;
		logic        e;
	} csab_row_t;
	logic        CORE_CLK, SRST, AVS_READ, AVS_WRITE, REQ_VALID, REQ_WRITE;
	logic        EXT_BUS_REQUEST, stall;
	logic [10:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, REQ_ADDR, REQ_WDATA, q;
	logic [3:0]  AVS_BYTEENABLE;
	logic [1:0]  REQ_SIZE;
	wire  [31:0] AVS_READDATA, RSP_RDATA;
	wire  [23:0] MEM_ADDR;
	wire  [15:0] MEM_DATA_OUT, MEM_DATA_IN;
	wire         AVS_WAITREQUEST, REQ_READY, RSP_VALID, RSP_ERR, MEM_CLK;
	wire         MEM_CS0_N, MEM_RD_N, MEM_WR0_N, MEM_WR1_N, MEM_DATA_OE_N;
	wire         MEM_RDY, MEM_CTRL_OE_N, MEM_PULLUP_EN, EXT_BUS_GRANT;
	wire         INT_MEM_EN;
	int          n_errors, checks_done;
	csab_row_t   rows [10] = '{
		'{1'b1, 2'h2, 32'h0010_0000, 32'h1122_3344, 32'h0, 1'b0},
		'{1'b0, 2'h2, 32'h0010_0000, 32'h0, 32'h1122_3344, 1'b0},
		'{1'b1, 2'h1, 32'h0010_0006, 32'h0000_abcd, 32'h0, 1'b0},
		'{1'b0, 2'h2, 32'h0010_0004, 32'h0, 32'h0000_abcd, 1'b0},
		'{1'b1, 2'h0, 32'h0010_0009, 32'h0000_00ee, 32'h0, 1'b0},
		'{1'b0, 2'h2, 32'h0010_0008, 32'h0, 32'h00ee_0000, 1'b0},
		'{1'b0, 2'h2, 32'h002f_fffc, 32'h0, 32'h0, 1'b0},
		'{1'b0, 2'h2, 32'h0030_0000, 32'h0, 32'h0, 1'b1},
		'{1'b0, 2'h2, 32'h000f_fffc, 32'h0, 32'h0, 1'b1},
		'{1'b1, 2'h2, 32'h0030_0000, 32'h1, 32'h0, 1'b1}};
	csab_top dut_u (.CORE_CLK, .SRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
		.AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
		.REQ_VALID, .REQ_READY, .REQ_WRITE, .REQ_SIZE, .REQ_ADDR, .REQ_WDATA,
		.RSP_VALID, .RSP_RDATA, .RSP_ERR, .MEM_CLK, .MEM_ADDR, .MEM_CS0_N,
		.MEM_RD_N, .MEM_WR0_N, .MEM_WR1_N, .MEM_DATA_OUT, .MEM_DATA_OE_N,
		.MEM_DATA_IN, .MEM_RDY, .MEM_CTRL_OE_N, .MEM_PULLUP_EN,
		.EXT_BUS_REQUEST, .EXT_BUS_GRANT, .INT_MEM_EN);
	csab_sram_model mem_u (.clk(CORE_CLK), .stall, .addr(MEM_ADDR),
		.cs_n(MEM_CS0_N), .rd_n(MEM_RD_N), .wr0_n(MEM_WR0_N),
		.wr1_n(MEM_WR1_N), .dout(MEM_DATA_IN), .rdy(MEM_RDY),
		.din(MEM_DATA_OE_N ? 16'hzzzz : MEM_DATA_OUT));
	// ------------------
	// clock, checks, end
	// ------------------
	initial begin
		CORE_CLK = 1'b0;
		forever #10 CORE_CLK = ~CORE_CLK;
	end
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic cmp_data(input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, exp);
		cmp_data({31'h0, got}, {31'h0, exp});
	endtask
	// avalon master: hold until waitrequest seen low at an edge
	task automatic avs(input logic w, input logic [10:0] a,
		input logic [31:0] d, output logic [31:0] r);
		logic wt;
		int k;
		@(posedge CORE_CLK);
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		k = 0;
		// waitrequest and read data as they stand at the rising edge
		do begin
			@(posedge CORE_CLK);
			wt = AVS_WAITREQUEST;
			r = AVS_READDATA;
			k++;
		end while (wt !== 1'b0 && k < 64);
		if (wt !== 1'b0) cmp_bit(wt, 1'b0);
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
	endtask
	task automatic rchk(input logic [10:0] a, input logic [31:0] x);
		avs(1'b0, a, 32'h0, q);
		cmp_data(q, x);
	endtask
	// memory request: hold until taken, then wait for the response
	task automatic run(input csab_row_t t);
		logic v;
		int k;
		@(posedge CORE_CLK);
		REQ_VALID <= 1'b1;
		REQ_WRITE <= t.w;
		REQ_SIZE <= t.s;
		REQ_ADDR <= t.a;
		REQ_WDATA <= t.d;
		k = 0;
		do begin
			@(negedge CORE_CLK);
			v = REQ_READY;
			k++;
			@(posedge CORE_CLK);
		end while (!v && k < 64);
		REQ_VALID <= 1'b0;
		k = 0;
		do begin
			@(negedge CORE_CLK);
			v = RSP_VALID;
			k++;
		end while (!v && k < 400);
		cmp_bit(v, 1'b1);
		cmp_bit(RSP_ERR, t.e);
		if (!t.w && !t.e) cmp_data(RSP_RDATA, t.x);
	endtask
	task automatic rq(input logic w, input logic [1:0] s,
		input logic [31:0] a, d, x, input logic f);
		csab_row_t t;
		t = '{w, s, a, d, x, f};
		run(t);
	endtask
	// watchdog well beyond the several hundred cycles the tests need
	initial begin
		#1000000;
		n_errors++;
		end_sim;
	end
	initial begin
		SRST = 1'b1;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_ADDRESS = 11'h0;
		AVS_WRITEDATA = 32'h0;
		AVS_BYTEENABLE = 4'hf;
		REQ_VALID = 1'b0;
		REQ_WRITE = 1'b0;
		REQ_SIZE = 2'h0;
		REQ_ADDR = 32'h0;
		REQ_WDATA = 32'h0;
		EXT_BUS_REQUEST = 1'b1;
		stall = 1'b1;
		repeat (12) @(posedge CORE_CLK);
		SRST <= 1'b0;
		avs(1'b1, 11'h7fd, 32'h5, q);
		@(negedge CORE_CLK);
		cmp_bit(INT_MEM_EN, 1'b1);
		rchk(11'h7fd, 32'h5);
		rchk(11'h642, 32'h0422);
		avs(1'b1, 11'h640, 32'h0010, q);
		avs(1'b1, 11'h642, 32'h5462, q);
		avs(1'b1, 11'h660, 32'h2058, q);
		rchk(11'h640, 32'h0010);
		rchk(11'h642, 32'h5462);
		rchk(11'h660, 32'h2058);
		avs(1'b1, 11'h7fe, 32'hffff, q);
		rchk(11'h7fe, 32'h0);
		for (int i = 0; i < 10; i++) run(rows[i]);
		cmp_bit(EXT_BUS_GRANT, 1'b0);
		rq(1'b0, 2'h2, 32'h0010_0010, 32'h0, 32'h0, 1'b0);
		mem_u.mem[8] = 16'h1234;
		rq(1'b0, 2'h2, 32'h0010_0010, 32'h0, 32'h0, 1'b0);
		rq(1'b1, 2'h1, 32'h0010_0020, 32'h0, 32'h0, 1'b0);
		rq(1'b0, 2'h2, 32'h0010_0010, 32'h0, 32'h1234_0000, 1'b0);
		avs(1'b1, 11'h642, 32'h5472, q);
		rq(1'b0, 2'h2, 32'h0010_0000, 32'h0, 32'h3344_1122, 1'b0);
		avs(1'b1, 11'h642, 32'h5442, q);
		rq(1'b1, 2'h2, 32'h0010_0000, 32'h5, 32'h0, 1'b1);
		rchk(11'h681, 32'h2);
		avs(1'b1, 11'h681, 32'h2, q);
		rchk(11'h681, 32'h0);
		avs(1'b1, 11'h642, 32'h5462, q);
		rq(1'b0, 2'h2, 32'h0010_0000, 32'h0, 32'h1122_3344, 1'b0);
		// ready input honoured once the access type is not write strobe
		avs(1'b1, 11'h642, 32'h5421, q);
		fork
			rq(1'b0, 2'h2, 32'h0010_0000, 32'h0, 32'h1122_3344, 1'b0);
			begin
				repeat (40) @(negedge CORE_CLK);
				cmp_bit(MEM_RD_N, 1'b0);
				@(posedge CORE_CLK);
				stall <= 1'b0;
			end
		join
		avs(1'b1, 11'h642, 32'h54e2, q);
		repeat (2) @(negedge CORE_CLK);
		cmp_bit(EXT_BUS_GRANT, 1'b1);
		cmp_bit(REQ_READY, 1'b0);
		cmp_bit(MEM_CTRL_OE_N, 1'b1);
		avs(1'b1, 11'h642, 32'h5462, q);
		avs(1'b1, 11'h680, 32'h4, q);
		@(negedge CORE_CLK);
		cmp_bit(MEM_PULLUP_EN, 1'b1);
		avs(1'b1, 11'h680, 32'h7, q);
		@(negedge CORE_CLK);
		cmp_bit(MEM_PULLUP_EN, 1'b0);
		cmp_bit(MEM_CTRL_OE_N, 1'b1);
		avs(1'b1, 11'h680, 32'h0, q);
		@(posedge CORE_CLK);
		SRST <= 1'b1;
		repeat (12) @(posedge CORE_CLK);
		SRST <= 1'b0;
		@(negedge CORE_CLK);
		cmp_bit(MEM_RD_N & MEM_WR0_N & MEM_WR1_N, 1'b1);
		cmp_bit(MEM_CLK, 1'b0);
		@(negedge CORE_CLK);
		cmp_bit(MEM_CLK, 1'b1);
		rchk(11'h640, 32'h0);
		rchk(11'h642, 32'h0022);
		rchk(11'h660, 32'h0);
		rchk(11'h7fd, 32'h0);
		end_sim;
	end
endmodule // test_chip_select_area_bus_config
`default_nettype wire
